// ### dsc_regs.sv
// Status and configuration register bank of the dual converter
// How it works
// - Software sync bit substitutes external sync.
// - Select bit makes software sync sole source.
// - Self-test failure sets flag; zero-write clears.
// - Self-test flag drives serial out when enabled.
// - FIFO pointer overrun sets sticky FIFO flag.
// - Unmasked compare flags non-checkerboard samples.
// - Width bit picks four- or three-pin serial.
// - Reverse bit swaps input bus bit order.
// - Disable bits skip divider and FIFO sync.
// - Bypass bits bypass the DLL and PLL.
// - Hold-sync disable blocks sync to hold block.
// - Sleep bits per converter, PLL and DLL.
// - Four-bit gain per converter, reset all ones.
// - Restart bit resets DLL and clears lock.
// - Feedback divider thermometer code, one to 32.
// - Reference divider thermometer code, one to eight.
// - Delay field in five-degree steps around 90.
// - Invert bit and bias field; code 100 forbidden.
// - Loop-filter reset bit discharges the filter.
// - Half-rate bit halves the PLL output clock.
`timescale 1ns/100ps
`default_nettype none
module dsc_regs (
   input wire logic clock_i, // 100 MHz clock
   input wire logic rstn_i, // Synchronous reset, active low
   input wire logic reg_wr_i, // Register write strobe
   input wire logic reg_rd_i, // Register read strobe
   input wire logic [4:0] reg_addr_i, // Register address
   input wire logic [7:0] reg_wdata_i, // Write data
   output logic [7:0] reg_rdata_o, // Read data
   input wire logic ext_sync_i, // External sync pin level
   input wire logic soft_sync_bit_i, // Software sync control bit
   input wire logic soft_sync_select_i, // Software sync select bit
   input wire logic selftest_enable_i, // Self test enabled
   input wire logic selftest_fail_i, // Self test failure pulse
   input wire logic fifo_overrun_i, // FIFO pointer overrun pulse
   input wire logic pattern_mask_i, // Pattern error mask
   input wire logic sample_valid_i, // FIFO sample valid
   input wire logic [15:0] sample_i, // FIFO sample
   input wire logic [15:0] lvds_data_i, // Input data bus
   input wire logic serial_data_i, // Serial engine data out
   output logic [15:0] data_o, // Input bus after optional reversal
   output logic serial_out_pin_o, // Serial data output pin
   output logic four_wire_serial_select_o, // Serial port width mode
   output logic dll_lock_clear_o, // Clears DLL lock indicator
   output var dsc_pkg::dsc_sync_s sync_o, // Routed sync controls
   output var dsc_pkg::dsc_analog_ctrl_s analog_o // Analog control bundle
);
   import dsc_pkg::*;

   default clocking cb_main @(posedge clock_i);
   endclocking
   default disable iff (!rstn_i);

   // ************************************************
   // Register storage
   // ************************************************
   logic [7:0] error_flags_ff;
   logic [7:0] if_bypass_ff;
   logic [7:0] sleep_bias_ff;
   logic [7:0] output_gain_ff;
   logic [7:0] dll_restart_ff;
   logic [7:0] pll_dividers_ff;
   logic [7:0] dll_tuning_ff;
   logic [7:0] pll_tuning_ff;
   logic sync_meta_ff;
   logic sync_pin_ff;
   logic pattern_bad;
   logic [7:0] nxt_error_flags;
   logic flag_wr;
   logic [15:0] reversed;

   assign flag_wr = reg_wr_i && (reg_addr_i == ADDR_ERROR_FLAGS);

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         if_bypass_ff <= RST_IF_BYPASS;
         sleep_bias_ff <= RST_SLEEP_BIAS;
         output_gain_ff <= RST_OUTPUT_GAIN;
         dll_restart_ff <= RST_ZERO;
         pll_dividers_ff <= RST_ZERO;
         dll_tuning_ff <= RST_ZERO;
         pll_tuning_ff <= RST_ZERO;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            ADDR_IF_BYPASS: if_bypass_ff <= reg_wdata_i & MASK_IF_BYPASS;
            ADDR_SLEEP_BIAS: sleep_bias_ff <= reg_wdata_i & MASK_SLEEP_BIAS;
            ADDR_OUTPUT_GAIN: output_gain_ff <= reg_wdata_i;
            ADDR_DLL_RESTART: dll_restart_ff <= reg_wdata_i & MASK_DLL_RESTART;
            ADDR_PLL_DIVIDERS: pll_dividers_ff <= reg_wdata_i;
            ADDR_DLL_TUNING: dll_tuning_ff <= reg_wdata_i;
            ADDR_PLL_TUNING: pll_tuning_ff <= reg_wdata_i;
            default: ;
         endcase
      end
   end

   // ************************************************
   // Sticky error flags
   // ************************************************
   // Pattern compare only while unmasked and a sample arrives
   assign pattern_bad = !pattern_mask_i && sample_valid_i &&
                        (sample_i != PATTERN_A) && (sample_i != PATTERN_B);

   always_comb begin
      nxt_error_flags = error_flags_ff;
      if (flag_wr) begin
         // Writing one leaves a flag alone, zero clears it
         nxt_error_flags = error_flags_ff & (reg_wdata_i | ~MASK_ERROR_FLAGS);
      end
      // Set beats a same-cycle clear
      if (selftest_fail_i) begin
         nxt_error_flags[BIT_SELFTEST_ERR] = 1'b1;
      end
      if (fifo_overrun_i) begin
         nxt_error_flags[BIT_FIFO_ERR] = 1'b1;
      end
      if (pattern_bad) begin
         nxt_error_flags[BIT_PATTERN_ERR] = 1'b1;
      end
      nxt_error_flags = nxt_error_flags & MASK_ERROR_FLAGS;
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         error_flags_ff <= RST_ZERO;
      end else begin
         error_flags_ff <= nxt_error_flags;
      end
   end

   // ************************************************
   // Read port
   // ************************************************
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         reg_rdata_o <= RST_ZERO;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            ADDR_ERROR_FLAGS: reg_rdata_o <= error_flags_ff;
            ADDR_IF_BYPASS: reg_rdata_o <= if_bypass_ff;
            ADDR_SLEEP_BIAS: reg_rdata_o <= sleep_bias_ff;
            ADDR_OUTPUT_GAIN: reg_rdata_o <= output_gain_ff;
            ADDR_DLL_RESTART: reg_rdata_o <= dll_restart_ff;
            ADDR_PLL_DIVIDERS: reg_rdata_o <= pll_dividers_ff;
            ADDR_DLL_TUNING: reg_rdata_o <= dll_tuning_ff;
            ADDR_PLL_TUNING: reg_rdata_o <= pll_tuning_ff;
            default: reg_rdata_o <= RST_ZERO;
         endcase
      end
   end

   // ************************************************
   // Sync routing
   // ************************************************
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         sync_meta_ff <= 1'b0;
         sync_pin_ff <= 1'b0;
      end else begin
         sync_meta_ff <= ext_sync_i;
         sync_pin_ff <= sync_meta_ff;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         sync_o <= '0;
      end else begin
         // Pins ignored entirely when software sync is selected
         sync_o.sync_level <= soft_sync_select_i ? soft_sync_bit_i : sync_pin_ff;
         sync_o.clkdiv_sync <= (soft_sync_select_i ? soft_sync_bit_i : sync_pin_ff) &&
                               !if_bypass_ff[BIT_CLKDIV_SYNC_DIS];
         sync_o.fifo_offset_sync <= (soft_sync_select_i ? soft_sync_bit_i : sync_pin_ff) &&
                                    !if_bypass_ff[BIT_FIFO_SYNC_DIS];
         sync_o.hold_sync <= (soft_sync_select_i ? soft_sync_bit_i : sync_pin_ff) &&
                             !sleep_bias_ff[BIT_HOLD_SYNC_DIS];
      end
   end

   // ************************************************
   // Data bus reversal and serial output
   // ************************************************
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_rev
         assign reversed[gi] = lvds_data_i[15 - gi];
      end
   endgenerate

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         data_o <= '0;
      end else begin
         data_o <= if_bypass_ff[BIT_REV_BUS] ? reversed : lvds_data_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         serial_out_pin_o <= 1'b0;
         four_wire_serial_select_o <= 1'b0;
      end else begin
         four_wire_serial_select_o <= if_bypass_ff[BIT_FOUR_WIRE];
         // Self-test flag overrides serial data while the test runs
         serial_out_pin_o <= selftest_enable_i ? error_flags_ff[BIT_SELFTEST_ERR]
                                               : serial_data_i;
      end
   end

   // ************************************************
   // Analog control decode
   // ************************************************
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         analog_o <= '0;
         dll_lock_clear_o <= 1'b0;
      end else begin
         analog_o.dll_bypass <= if_bypass_ff[BIT_DLL_BYPASS];
         analog_o.pll_bypass <= if_bypass_ff[BIT_PLL_BYPASS];
         analog_o.sleep_a <= sleep_bias_ff[BIT_SLEEP_A];
         analog_o.sleep_b <= sleep_bias_ff[BIT_SLEEP_B];
         analog_o.pll_sleep <= sleep_bias_ff[BIT_PLL_SLEEP];
         analog_o.dll_sleep <= sleep_bias_ff[BIT_DLL_SLEEP];
         analog_o.bias_lpf_a <= sleep_bias_ff[BIT_BIAS_LPF_A];
         analog_o.bias_lpf_b <= sleep_bias_ff[BIT_BIAS_LPF_B];
         analog_o.converter_a_current_scale <= output_gain_ff[7:4];
         analog_o.converter_b_current_scale <= output_gain_ff[3:0];
         analog_o.dll_loop_reset <= dll_restart_ff[BIT_DLL_RESTART];
         dll_lock_clear_o <= dll_restart_ff[BIT_DLL_RESTART];
         // Invalid codes flagged; ratio then reads zero
         case (pll_dividers_ff[7:3])
            PLL_M_1: analog_o.pll_m_ratio <= 6'h01;
            PLL_M_2: analog_o.pll_m_ratio <= 6'h02;
            PLL_M_4: analog_o.pll_m_ratio <= 6'h04;
            PLL_M_8: analog_o.pll_m_ratio <= 6'h08;
            PLL_M_16: analog_o.pll_m_ratio <= 6'h10;
            PLL_M_32: analog_o.pll_m_ratio <= 6'h20;
            default: analog_o.pll_m_ratio <= 6'h00;
         endcase
         case (pll_dividers_ff[2:0])
            PLL_N_1: analog_o.pll_n_ratio <= 4'h1;
            PLL_N_2: analog_o.pll_n_ratio <= 4'h2;
            PLL_N_4: analog_o.pll_n_ratio <= 4'h4;
            PLL_N_8: analog_o.pll_n_ratio <= 4'h8;
            default: analog_o.pll_n_ratio <= 4'h0;
         endcase
         analog_o.pll_div_invalid <= !(pll_dividers_ff[7:3] inside
            {PLL_M_1, PLL_M_2, PLL_M_4, PLL_M_8, PLL_M_16, PLL_M_32}) ||
            !(pll_dividers_ff[2:0] inside {PLL_N_1, PLL_N_2, PLL_N_4, PLL_N_8});
         // Signed four-bit step around the 90-degree centre
         analog_o.dll_delay_degrees <= DLL_DEG_CENTER +
            8'(signed'(dll_tuning_ff[7:4]) * signed'(DLL_DEG_STEP));
         analog_o.dll_invert_clock <= dll_tuning_ff[BIT_DLL_INVCLK];
         analog_o.dll_bias <= dll_tuning_ff[2:0];
         analog_o.dll_bias_invalid <= (dll_tuning_ff[2:0] == BIAS_FORBIDDEN);
         analog_o.loop_filter_discharge <= pll_tuning_ff[BIT_LOOP_FILTER_DISCHARGE];
         analog_o.oscillator_half_rate <= pll_tuning_ff[BIT_OSC_HALF_RATE];
         analog_o.pll_gain <= pll_tuning_ff[5:4];
         analog_o.pll_range <= pll_tuning_ff[3:0];
      end
   end

   // ************************************************
   // Checks
   // ************************************************
   sequence s_flag_zero_write;
      flag_wr && !reg_wdata_i[BIT_FIFO_ERR] && !fifo_overrun_i;
   endsequence
   // Restart takes two writes: set, then clear
   sequence s_restart_set;
      reg_wr_i && (reg_addr_i == ADDR_DLL_RESTART) && reg_wdata_i[BIT_DLL_RESTART];
   endsequence
   sequence s_restart_clear;
      reg_wr_i && (reg_addr_i == ADDR_DLL_RESTART) && !reg_wdata_i[BIT_DLL_RESTART];
   endsequence

   AST_SELFTEST_SET: assert property (
      selftest_fail_i |=> error_flags_ff[BIT_SELFTEST_ERR])
      else $error("self test flag not set");
   AST_SELFTEST_CLEAR: assert property (
      flag_wr && !reg_wdata_i[BIT_SELFTEST_ERR] && !selftest_fail_i |=> !error_flags_ff[BIT_SELFTEST_ERR])
      else $error("self test flag not cleared");
   AST_FIFO_SET: assert property (
      fifo_overrun_i |=> error_flags_ff[BIT_FIFO_ERR])
      else $error("fifo flag not set");
   AST_FIFO_CLEAR: assert property (
      s_flag_zero_write |=> !error_flags_ff[BIT_FIFO_ERR])
      else $error("fifo flag not cleared");
   AST_FLAG_STICKY: assert property (
      error_flags_ff[BIT_PATTERN_ERR] && !flag_wr |=> error_flags_ff[BIT_PATTERN_ERR])
      else $error("pattern flag dropped");
   AST_FLAG_WRITE_ONE: assert property (
      flag_wr && reg_wdata_i[BIT_SELFTEST_ERR] && error_flags_ff[BIT_SELFTEST_ERR] |=>
      error_flags_ff[BIT_SELFTEST_ERR])
      else $error("writing one cleared a flag");
   AST_PATTERN_SET: assert property (
      pattern_bad |=> error_flags_ff[BIT_PATTERN_ERR])
      else $error("pattern flag not set");
   AST_PATTERN_GOOD: assert property (
      !error_flags_ff[BIT_PATTERN_ERR] && !pattern_bad |=> !error_flags_ff[BIT_PATTERN_ERR])
      else $error("pattern flag set spuriously");
   AST_SOFT_SYNC: assert property (
      soft_sync_select_i |=> sync_o.sync_level == $past(soft_sync_bit_i))
      else $error("software sync not used");
   AST_PIN_SYNC: assert property (
      !soft_sync_select_i |=> sync_o.sync_level == $past(sync_pin_ff))
      else $error("pin sync not used");
   AST_CLKDIV_SYNC_DIS: assert property (
      if_bypass_ff[BIT_CLKDIV_SYNC_DIS] |=> !sync_o.clkdiv_sync)
      else $error("divider sync not blocked");
   AST_FIFO_SYNC_DIS: assert property (
      if_bypass_ff[BIT_FIFO_SYNC_DIS] |=> !sync_o.fifo_offset_sync)
      else $error("fifo offset sync not blocked");
   AST_REV_BUS: assert property (
      if_bypass_ff[BIT_REV_BUS] |=> data_o[15] == $past(lvds_data_i[0]))
      else $error("bus not reversed");
   AST_SERIAL_SELFTEST: assert property (
      selftest_enable_i |=> serial_out_pin_o == $past(error_flags_ff[BIT_SELFTEST_ERR]))
      else $error("serial out not showing self test flag");
   AST_HOLD_SYNC: assert property (
      sleep_bias_ff[BIT_HOLD_SYNC_DIS] |=> !sync_o.hold_sync)
      else $error("hold sync not blocked");
   AST_FOUR_WIRE: assert property (
      $past(rstn_i) |-> four_wire_serial_select_o == $past(if_bypass_ff[BIT_FOUR_WIRE]))
      else $error("serial width mode wrong");
   AST_BYPASS: assert property (
      $past(rstn_i) |-> {analog_o.dll_bypass, analog_o.pll_bypass} ==
      $past({if_bypass_ff[BIT_DLL_BYPASS], if_bypass_ff[BIT_PLL_BYPASS]}))
      else $error("bypass controls wrong");
   AST_SLEEP: assert property (
      $past(rstn_i) |-> {analog_o.sleep_a, analog_o.sleep_b, analog_o.pll_sleep, analog_o.dll_sleep} ==
      $past({sleep_bias_ff[BIT_SLEEP_A], sleep_bias_ff[BIT_SLEEP_B], sleep_bias_ff[BIT_PLL_SLEEP],
      sleep_bias_ff[BIT_DLL_SLEEP]}))
      else $error("sleep controls wrong");
   AST_GAIN: assert property (
      $past(rstn_i) |-> {analog_o.converter_a_current_scale, analog_o.converter_b_current_scale} ==
      $past(output_gain_ff))
      else $error("gain fields wrong");
   AST_DLL_RESTART: assert property (
      s_restart_set |=> ##1 (dll_lock_clear_o && analog_o.dll_loop_reset))
      else $error("restart did not reset loop");
   AST_DLL_RELEASE: assert property (
      s_restart_clear |=> ##1 (!dll_lock_clear_o && !analog_o.dll_loop_reset))
      else $error("restart not released");
   AST_M_RATIO: assert property (
      $past(rstn_i) |-> $onehot(analog_o.pll_m_ratio) || analog_o.pll_div_invalid)
      else $error("feedback ratio not a power of two");
   AST_N_RATIO: assert property (
      $past(rstn_i) |-> $onehot(analog_o.pll_n_ratio) || analog_o.pll_div_invalid)
      else $error("reference ratio not a power of two");
   AST_DELAY_RANGE: assert property (
      $past(rstn_i) |-> analog_o.dll_delay_degrees inside {[8'h32:8'h7D]})
      else $error("delay outside its range");
   AST_BIAS_BAD: assert property (
      $past(rstn_i) |-> analog_o.dll_bias_invalid == ($past(dll_tuning_ff[2:0]) == BIAS_FORBIDDEN))
      else $error("forbidden bias code not flagged");
   AST_LOOP_FILTER: assert property (
      $past(rstn_i) |->
      analog_o.loop_filter_discharge == $past(pll_tuning_ff[BIT_LOOP_FILTER_DISCHARGE]))
      else $error("loop filter discharge wrong");
   AST_HALF_RATE: assert property (
      $past(rstn_i) |-> analog_o.oscillator_half_rate == $past(pll_tuning_ff[BIT_OSC_HALF_RATE]))
      else $error("half rate control wrong");
endmodule : dsc_regs
`default_nettype wire

// ### dsc_pkg.sv
// Package for the converter status and configuration register bank
`default_nettype none
package dsc_pkg;
   // Register offsets
   localparam logic [4:0] ADDR_ERROR_FLAGS = 5'h04;
   localparam logic [4:0] ADDR_IF_BYPASS = 5'h05;
   localparam logic [4:0] ADDR_SLEEP_BIAS = 5'h06;
   localparam logic [4:0] ADDR_OUTPUT_GAIN = 5'h07;
   localparam logic [4:0] ADDR_DLL_RESTART = 5'h08;
   localparam logic [4:0] ADDR_PLL_DIVIDERS = 5'h09;
   localparam logic [4:0] ADDR_DLL_TUNING = 5'h0A;
   localparam logic [4:0] ADDR_PLL_TUNING = 5'h0B;
   // Reset values
   localparam logic [7:0] RST_IF_BYPASS = 8'h00;
   localparam logic [7:0] RST_SLEEP_BIAS = 8'h0C;
   localparam logic [7:0] RST_OUTPUT_GAIN = 8'hFF;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // Error flag bit positions
   localparam int BIT_SELFTEST_ERR = 6;
   localparam int BIT_FIFO_ERR = 5;
   localparam int BIT_PATTERN_ERR = 4;
   // Interface/bypass bits
   localparam int BIT_FOUR_WIRE = 7;
   localparam int BIT_REV_BUS = 6;
   localparam int BIT_CLKDIV_SYNC_DIS = 5;
   localparam int BIT_FIFO_SYNC_DIS = 4;
   localparam int BIT_DLL_BYPASS = 2;
   localparam int BIT_PLL_BYPASS = 1;
   // Sleep/bias bits, then restart and DLL/PLL tuning bits
   localparam int BIT_HOLD_SYNC_DIS = 7;
   localparam int BIT_SLEEP_B = 5;
   localparam int BIT_SLEEP_A = 4;
   localparam int BIT_BIAS_LPF_A = 3;
   localparam int BIT_BIAS_LPF_B = 2;
   localparam int BIT_PLL_SLEEP = 1;
   localparam int BIT_DLL_SLEEP = 0;
   localparam int BIT_DLL_RESTART = 2;
   localparam int BIT_LOOP_FILTER_DISCHARGE = 7;
   localparam int BIT_OSC_HALF_RATE = 6;
   localparam int BIT_DLL_INVCLK = 3;
   // Writable masks (reserved bits forced to zero)
   localparam logic [7:0] MASK_ERROR_FLAGS = 8'h70;
   localparam logic [7:0] MASK_IF_BYPASS = 8'hF6;
   localparam logic [7:0] MASK_SLEEP_BIAS = 8'hBF;
   localparam logic [7:0] MASK_DLL_RESTART = 8'h04;
   // Checkerboard patterns
   localparam logic [15:0] PATTERN_A = 16'hAAAA;
   localparam logic [15:0] PATTERN_B = 16'h5555;
   // Divider ratios, forbidden bias code and delay constants
   localparam logic [4:0] PLL_M_1 = 5'h00;
   localparam logic [4:0] PLL_M_2 = 5'h01;
   localparam logic [4:0] PLL_M_4 = 5'h03;
   localparam logic [4:0] PLL_M_8 = 5'h07;
   localparam logic [4:0] PLL_M_16 = 5'h0F;
   localparam logic [4:0] PLL_M_32 = 5'h1F;
   localparam logic [2:0] PLL_N_1 = 3'h0;
   localparam logic [2:0] PLL_N_2 = 3'h1;
   localparam logic [2:0] PLL_N_4 = 3'h3;
   localparam logic [2:0] PLL_N_8 = 3'h7;
   localparam logic [2:0] BIAS_FORBIDDEN = 3'h4;
   localparam logic [7:0] DLL_DEG_CENTER = 8'h5A;
   localparam logic [7:0] DLL_DEG_STEP = 8'h05;

   // Analog-facing control bundle
   typedef struct packed {
      logic dll_bypass;
      logic pll_bypass;
      logic sleep_a;
      logic sleep_b;
      logic pll_sleep;
      logic dll_sleep;
      logic bias_lpf_a;
      logic bias_lpf_b;
      logic [3:0] converter_a_current_scale;
      logic [3:0] converter_b_current_scale;
      logic dll_loop_reset;
      logic [5:0] pll_m_ratio;
      logic [3:0] pll_n_ratio;
      logic pll_div_invalid;
      logic [7:0] dll_delay_degrees;
      logic dll_invert_clock;
      logic [2:0] dll_bias;
      logic dll_bias_invalid;
      logic loop_filter_discharge;
      logic oscillator_half_rate;
      logic [1:0] pll_gain;
      logic [3:0] pll_range;
   } dsc_analog_ctrl_s;

   // Sync routing bundle
   typedef struct packed {
      logic sync_level;
      logic clkdiv_sync;
      logic fifo_offset_sync;
      logic hold_sync;
   } dsc_sync_s;
endpackage : dsc_pkg
`default_nettype wire

// ### dsc_regs_tb_top.sv
// Self-checking testbench for the converter register bank
`timescale 1ns/100ps
`default_nettype none
module dsc_regs_tb_top;
   import dsc_pkg::*;
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [7:0] wdata = 8'h00;
   logic ext_sync = 1'b0;
   logic soft_bit = 1'b0;
   logic soft_sel = 1'b0;
   logic st_en = 1'b0;
   logic st_fail = 1'b0;
   logic fifo_ovr = 1'b0;
   logic pat_mask = 1'b1;
   logic smp_vld = 1'b0;
   logic [15:0] smp = 16'h0000;
   logic [15:0] lvds = 16'h0000;
   logic ser_in = 1'b0;
   logic [7:0] rdata;
   logic [15:0] data;
   logic ser_out;
   logic four_wire;
   logic lock_clr;
   dsc_sync_s syn;
   dsc_analog_ctrl_s ana;
   int bad_count = 0;
   int cmp_count = 0;

   dsc_regs i_dsc_regs (.clock_i(clock_i), .rstn_i(rstn_i), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .ext_sync_i(ext_sync),
      .soft_sync_bit_i(soft_bit), .soft_sync_select_i(soft_sel), .selftest_enable_i(st_en),
      .selftest_fail_i(st_fail), .fifo_overrun_i(fifo_ovr), .pattern_mask_i(pat_mask),
      .sample_valid_i(smp_vld), .sample_i(smp), .lvds_data_i(lvds), .serial_data_i(ser_in),
      .data_o(data), .serial_out_pin_o(ser_out), .four_wire_serial_select_o(four_wire),
      .dll_lock_clear_o(lock_clr), .sync_o(syn), .analog_o(ana));

   initial begin
      forever #5 clock_i = ~clock_i;
   end

   // ****************************************
   // Shared bus and compare tasks
   // ****************************************
   task automatic tick(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   // Strobe dropped for two cycles so back-to-back calls never re-drive it in one step
   task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
      tick(2);
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
      addr = a;
      rd = 1'b1;
      tick(1);
      rd = 1'b0;
      tick(1);
      chk($sformatf("reg %0h", a), 16'(e), 16'(rdata));
   endtask
   task automatic pulse(input int b);
      st_fail = (b == 6);
      fifo_ovr = (b == 5);
      tick(1);
      st_fail = 1'b0;
      fifo_ovr = 1'b0;
      tick(1);
   endtask
   // Odd samples are inverted, so AAAA alternates with 5555
   task automatic feed(input logic [15:0] s, input int n);
      for (int i = 0; i < n; i++) begin
         smp = (i % 2 == 1) ? ~s : s;
         smp_vld = 1'b1;
         tick(1);
      end
      smp_vld = 1'b0;
      tick(2);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      logic [7:0] ex [8] = '{8'h00, 8'h00, 8'h0C, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 8; i++) rd_chk(5'(i + 4), ex[i]);
      rd_chk(5'h1F, 8'h00);
      chk("gain", 16'h00FF, 16'({ana.converter_a_current_scale, ana.converter_b_current_scale}));
      chk("delay", 16'h005A, 16'(ana.dll_delay_degrees));
      chk("bias_lpf", 16'h0003, 16'({ana.bias_lpf_a, ana.bias_lpf_b}));
   endtask
   task automatic t_access;
      logic [7:0] msk [7] = '{8'hF6, 8'hBF, 8'hFF, 8'h04, 8'hFF, 8'hFF, 8'hFF};
      logic v;
      for (int k = 0; k < 2; k++) begin
         v = (k == 0);
         for (int i = 0; i < 7; i++) wr_reg(5'(i + 5), {8{v}});
         for (int i = 0; i < 7; i++) rd_chk(5'(i + 5), msk[i] & {8{v}});
         chk("four_wire", 16'(v), 16'(four_wire));
         chk("lock_clr", 16'(v), 16'(lock_clr));
         chk("bypass", 16'({2{v}}), 16'({ana.dll_bypass, ana.pll_bypass}));
         chk("sleep", 16'({4{v}}), 16'({ana.sleep_a, ana.sleep_b, ana.pll_sleep, ana.dll_sleep}));
         chk("lpf", 16'(v), 16'(ana.loop_filter_discharge));
         chk("half", 16'(v), 16'(ana.oscillator_half_rate));
         chk("m", v ? 16'd32 : 16'd1, 16'(ana.pll_m_ratio));
         chk("n", v ? 16'd8 : 16'd1, 16'(ana.pll_n_ratio));
         chk("delay", v ? 16'h0055 : 16'h005A, 16'(ana.dll_delay_degrees));
         chk("invclk", 16'(v), 16'(ana.dll_invert_clock));
         chk("bias_lpf", 16'({2{v}}), 16'({ana.bias_lpf_a, ana.bias_lpf_b}));
         chk("loop_rst", 16'(v), 16'(ana.dll_loop_reset));
         chk("gain_rng", 16'({6{v}}), 16'({ana.pll_gain, ana.pll_range}));
      end
      wr_reg(5'h1F, 8'hFF);
      rd_chk(5'h1F, 8'h00);
      wr_reg(5'h07, 8'h3C);
      chk("gain", 16'h003C, 16'({ana.converter_a_current_scale, ana.converter_b_current_scale}));
   endtask
   task automatic t_div;
      logic [4:0] mc [6] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h0F, 5'h1F};
      logic [2:0] nc [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
      for (int i = 0; i < 6; i++) begin
         wr_reg(5'h09, {mc[i], nc[i % 4]});
         chk("m", 16'(1 << i), 16'(ana.pll_m_ratio));
         chk("n", 16'(1 << (i % 4)), 16'(ana.pll_n_ratio));
         chk("div_bad", 16'h0000, 16'(ana.pll_div_invalid));
      end
      wr_reg(5'h09, {5'h02, 3'h0});
      chk("div_bad", 16'h0001, 16'(ana.pll_div_invalid));
      wr_reg(5'h09, {5'h00, 3'h2});
      chk("div_bad", 16'h0001, 16'(ana.pll_div_invalid));
   endtask
   task automatic t_dll;
      logic [3:0] dc [4] = '{4'h8, 4'h7, 4'h1, 4'h0};
      logic [2:0] bc [4] = '{3'h4, 3'h3, 3'h5, 3'h0};
      int deg [4] = '{50, 125, 95, 90};
      for (int i = 0; i < 4; i++) begin
         wr_reg(5'h0A, {dc[i], 1'b0, bc[i]});
         chk("delay", 16'(deg[i]), 16'(ana.dll_delay_degrees));
         chk("bias", 16'(bc[i]), 16'(ana.dll_bias));
         chk("bias_bad", 16'(i == 0), 16'(ana.dll_bias_invalid));
      end
      wr_reg(5'h08, 8'h04);
      chk("restart", 16'h0001, 16'(lock_clr));
      wr_reg(5'h08, 8'h00);
      chk("restart", 16'h0000, 16'(lock_clr));
   endtask
   task automatic t_flags;
      for (int b = 5; b < 7; b++) begin
         pulse(b);
         rd_chk(5'h04, 8'(1 << b));
         wr_reg(5'h04, 8'hFF);
         rd_chk(5'h04, 8'(1 << b));
         wr_reg(5'h04, 8'h00);
         rd_chk(5'h04, 8'h00);
      end
      pulse(5);
      pulse(6);
      wr_reg(5'h04, 8'h20);
      rd_chk(5'h04, 8'h20);
      // Overrun in the very cycle of a zero write: the set must win
      addr = 5'h04;
      wdata = 8'h00;
      wr = 1'b1;
      fifo_ovr = 1'b1;
      tick(1);
      wr = 1'b0;
      fifo_ovr = 1'b0;
      tick(1);
      rd_chk(5'h04, 8'h20);
      wr_reg(5'h04, 8'h00);
      feed(16'h1234, 1);
      rd_chk(5'h04, 8'h00);
      pat_mask = 1'b0;
      feed(16'hAAAA, 8);
      rd_chk(5'h04, 8'h00);
      feed(16'h1234, 1);
      rd_chk(5'h04, 8'h10);
      feed(16'hAAAA, 8);
      rd_chk(5'h04, 8'h10);
      wr_reg(5'h04, 8'h00);
      rd_chk(5'h04, 8'h00);
      pat_mask = 1'b1;
   endtask
   task automatic t_pins;
      ser_in = 1'b1;
      tick(2);
      chk("sdo", 16'h0001, 16'(ser_out));
      pulse(6);
      st_en = 1'b1;
      ser_in = 1'b0;
      tick(2);
      chk("sdo", 16'h0001, 16'(ser_out));
      wr_reg(5'h04, 8'h00);
      chk("sdo", 16'h0000, 16'(ser_out));
      st_en = 1'b0;
      lvds = 16'h1234;
      tick(2);
      chk("data", 16'h1234, data);
      wr_reg(5'h05, 8'h40);
      chk("data", 16'h2C48, data);
      wr_reg(5'h05, 8'h00);
   endtask
   task automatic t_sync;
      soft_sel = 1'b1;
      soft_bit = 1'b1;
      tick(4);
      chk("sync", 16'h000F, 16'(syn));
      soft_bit = 1'b0;
      ext_sync = 1'b1;
      tick(4);
      chk("sync", 16'h0000, 16'(syn));
      soft_sel = 1'b0;
      tick(4);
      chk("sync", 16'h000F, 16'(syn));
      wr_reg(5'h05, 8'h30);
      wr_reg(5'h06, 8'h8C);
      chk("sync", 16'h0008, 16'(syn));
      wr_reg(5'h05, 8'h20);
      chk("sync", 16'h000A, 16'(syn));
   endtask

   task automatic tally_and_finish;
      if (bad_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock_i);
      bad_count++;
      tally_and_finish();
   end

   initial begin
      tick(6);
      rstn_i = 1'b1;
      t_reset();
      t_access();
      t_div();
      t_dll();
      t_flags();
      t_pins();
      t_sync();
      // Mid-run reset must bring the bank back to its defaults
      rstn_i = 1'b0;
      tick(2);
      rstn_i = 1'b1;
      t_reset();
      tally_and_finish();
   end
endmodule // dsc_regs_tb_top
`default_nettype wire
